// ---- rtl/rmu_mem.sv ----
// rmu_mem: word-wide configuration memory holding the section words
// assumes contents are loaded over the user port before use
`default_nettype none
module rmu_mem
  import rmu_pkg::*;
#(
  parameter int unsigned DEPTH = MEM_WORDS
) (
  // clock
  input wire logic aclk,
  // port
  rmu_mem_if.mem   port
);
  logic [15:0] mem_q [DEPTH];
  logic [15:0] rdata_q;
  wire  [$clog2(DEPTH)-1:0] idx = port.addr[$clog2(DEPTH)-1:0];

  // no reset on the array: it models stored content, not control state
  always_ff @(posedge aclk) begin
    if (port.we) begin
      mem_q[idx] <= port.wdata;
    end
    rdata_q <= mem_q[idx];
  end
  assign port.rdata = rdata_q;
endmodule
`default_nettype wire

// ---- rtl/rmu_mem_if.sv ----
// rmu_mem_if: word read/write port into the configuration memory
// assumes one clock; reads return the next cycle
`default_nettype none
interface rmu_mem_if;
  logic [7:0]  addr;
  logic [15:0] rdata;
  logic        we;
  logic [15:0] wdata;
  modport user (output addr, output we, output wdata, input rdata);
  modport mem  (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

// ---- rtl/rmu_pkg.sv ----
// rmu_pkg: constants for the riser modem/usb map block
// assumes a 32-bit axi4-lite register bus with word-aligned registers
`default_nettype none
package rmu_pkg;
  // ---------------------------------------------------------------
  // memory layout
  // ---------------------------------------------------------------
  localparam int unsigned MEM_WORDS       = 64;
  localparam logic [7:0]  MODEM_PTR_WORD  = 8'h10;
  localparam logic [7:0]  USB_PTR_WORD    = 8'h12;
  localparam logic [7:0]  SECTION_WORDS   = 8'h02;
  localparam logic [7:0]  WORD2_OFFSET    = 8'h02;
  // ---------------------------------------------------------------
  // usb option word fields
  // ---------------------------------------------------------------
  localparam int unsigned OPT_HUB_BIT     = 3;
  localparam int unsigned OPT_WAKE_BIT    = 2;
  localparam int unsigned OPT_RSVD_LO     = 4;
  localparam logic [1:0]  USB_VER_1X      = 2'h0;
  localparam logic [1:0]  USB_VER_20      = 2'h1;
  localparam logic [7:0]  COMPL_UPPER     = 8'h01;
  localparam logic [7:0]  COMPL_LOWER     = 8'h00;
  localparam logic [15:0] WORD_RESET      = 16'h0000;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_MODEM_VENDOR = 8'h00;
  localparam logic [7:0] REG_MODEM_MODEL  = 8'h04;
  localparam logic [7:0] REG_USB_OPTION   = 8'h08;
  localparam logic [7:0] REG_USB_COMPL    = 8'h0c;
  localparam logic [7:0] REG_MODEM_PTR    = 8'h10;
  localparam logic [7:0] REG_USB_PTR      = 8'h14;
  localparam logic [7:0] REG_STATUS       = 8'h18;
  localparam logic [7:0] REG_MEM_ADDR     = 8'h1c;
  localparam logic [7:0] REG_MEM_DATA     = 8'h20;
  localparam logic [1:0] RESP_OKAY        = 2'h0;
  localparam logic [1:0] RESP_SLVERR      = 2'h2;
  // status bits
  localparam int unsigned ST_MODEM_OK     = 0;
  localparam int unsigned ST_USB_OK       = 1;
  localparam int unsigned ST_RSVD_OK      = 2;
  localparam int unsigned ST_VER_OK       = 3;
  localparam int unsigned ST_COMPL_OK     = 4;
  localparam int unsigned ST_MODEM_PRES   = 5;
  localparam int unsigned ST_USB_PRES     = 6;
  localparam int unsigned ST_BUSY         = 31;
endpackage
`default_nettype wire

// ---- rtl/rmu_top.sv ----
// rmu_top: modem and usb section map of the riser configuration memory
// assumes an axi4-lite master on aclk; memory filled through the window registers
//
// Overview of operation
// - nonzero modem pointer means a modem section exists at that address
// - modem section starts at pointer in word 10h, at most two words
// - first modem word is subsystem vendor id for the modem function
// - second modem word is the board model number, subsystem id
// - nonzero usb pointer means a usb section exists at that address
// - usb section starts at pointer in word 12h, at most two words
// - option bits fifteen to four are stored as zero
// - option bit three set when the usb function is a hub
// - option bit two set when the usb function can wake
// - option bits one-zero give usb version; 10 and 11 reserved
// - compliance word is 0100h: upper byte 01h, lower 00h
`default_nettype none
module rmu_top
  import rmu_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // decoded section fields
  output logic [15:0]      modem_vendor_bits,
  output logic [15:0]      modem_model_bits,
  output logic             hub_flag,
  output logic             wake_capable_flag,
  output logic [1:0]       usb_version_field,
  output logic [15:0]      usb_compliance_bits,
  output logic             map_valid
);
  // -------------------------------------------------------------
  // scan state machine
  // -------------------------------------------------------------
  typedef enum logic [6:0] {
    RMU_IDLE  = 7'b0000001,
    RMU_PTR_M = 7'b0000010,
    RMU_PTR_U = 7'b0000100,
    RMU_M0    = 7'b0001000,
    RMU_M1    = 7'b0010000,
    RMU_U0    = 7'b0100000,
    RMU_U1    = 7'b1000000
  } rmu_state_t;

  rmu_state_t  state_q;
  rmu_state_t  state_d;
  logic [15:0] modem_ptr_q;
  logic [15:0] usb_ptr_q;
  logic [15:0] mvend_q;
  logic [15:0] mmodel_q;
  logic [15:0] uopt_q;
  logic [15:0] ucompl_q;
  logic        valid_q;
  logic [7:0]  mem_addr_q;
  logic [7:0]  scan_addr;
  logic        scan_busy;
  logic        capture;

  rmu_mem_if mif ();

  rmu_mem #(
    .DEPTH (MEM_WORDS)
  ) u_mem (
    .aclk (aclk),
    .port (mif)
  );

  // -------------------------------------------------------------
  // axi write channel
  // -------------------------------------------------------------
  logic [7:0]  aw_addr_q;
  logic        aw_held_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        w_held_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;

  wire do_write   = aw_held_q && w_held_q && !bvalid_q;
  wire wr_hit_adr = (aw_addr_q == REG_MEM_ADDR);
  wire wr_hit_dat = (aw_addr_q == REG_MEM_DATA);
  wire wr_hit_go  = (aw_addr_q == REG_STATUS);
  wire wr_known   = wr_hit_adr || wr_hit_dat || wr_hit_go;
  wire mem_we     = do_write && wr_hit_dat && (w_strb_q[1:0] == 2'h3) && !scan_busy;
  wire start_scan = do_write && wr_hit_go && w_strb_q[0] && w_data_q[0];

  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // each half is held on its own, so address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end else if (s_axi_awvalid && !aw_held_q) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end else if (s_axi_wvalid && !w_held_q) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
  end

  // response waits for both halves; no new write is carried out until it is accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_addr_q <= 8'h00;
    end else if (do_write && wr_hit_adr && w_strb_q[0]) begin
      mem_addr_q <= w_data_q[7:0];
    end else if (mem_we) begin
      mem_addr_q <= mem_addr_q + 8'h01;
    end
  end

  // -------------------------------------------------------------
  // section scan
  // -------------------------------------------------------------
  // the scan walks pointers first, so a section is fetched only
  // from the address its own pointer word designates
  wire modem_present = (modem_ptr_q != WORD_RESET);
  wire usb_present   = (usb_ptr_q != WORD_RESET);

  always_comb begin
    unique case (state_q)
      RMU_PTR_M: scan_addr = MODEM_PTR_WORD;
      RMU_PTR_U: scan_addr = USB_PTR_WORD;
      RMU_M0:    scan_addr = modem_ptr_q[7:0];
      RMU_M1:    scan_addr = modem_ptr_q[7:0] + WORD2_OFFSET;
      RMU_U0:    scan_addr = usb_ptr_q[7:0];
      RMU_U1:    scan_addr = usb_ptr_q[7:0] + WORD2_OFFSET;
      default:   scan_addr = mem_addr_q;
    endcase
  end

  assign scan_busy = (state_q != RMU_IDLE);
  assign mif.addr  = scan_addr;
  assign mif.we    = mem_we;
  assign mif.wdata = w_data_q[15:0];

  always_comb begin
    unique case (state_q)
      RMU_IDLE:  state_d = start_scan ? RMU_PTR_M : RMU_IDLE;
      RMU_PTR_M: state_d = RMU_PTR_U;
      RMU_PTR_U: state_d = RMU_M0;
      RMU_M0:    state_d = RMU_M1;
      RMU_M1:    state_d = RMU_U0;
      RMU_U0:    state_d = RMU_U1;
      RMU_U1:    state_d = RMU_IDLE;
      default:   state_d = RMU_IDLE;
    endcase
  end

  // memory read data lags the address by one cycle
  rmu_state_t prev_q;
  assign capture = (prev_q != RMU_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= RMU_IDLE;
      prev_q  <= RMU_IDLE;
    end else begin
      state_q <= state_d;
      prev_q  <= state_q;
    end
  end

  // one capture enable per fetched word, decoded from the fetch state
  wire cap_mptr = capture && (prev_q == RMU_PTR_M);
  wire cap_uptr = capture && (prev_q == RMU_PTR_U);
  wire cap_m0   = capture && (prev_q == RMU_M0);
  wire cap_m1   = capture && (prev_q == RMU_M1);
  wire cap_u0   = capture && (prev_q == RMU_U0);
  wire cap_u1   = capture && (prev_q == RMU_U1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      modem_ptr_q <= WORD_RESET;
      usb_ptr_q   <= WORD_RESET;
    end else begin
      if (cap_mptr) begin
        modem_ptr_q <= mif.rdata;
      end
      if (cap_uptr) begin
        usb_ptr_q <= mif.rdata;
      end
    end
  end

  // an absent section reads as zero, not as whatever the memory holds there
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mvend_q  <= WORD_RESET;
      mmodel_q <= WORD_RESET;
    end else begin
      if (cap_m0) begin
        mvend_q <= modem_present ? mif.rdata : WORD_RESET;
      end
      if (cap_m1) begin
        mmodel_q <= modem_present ? mif.rdata : WORD_RESET;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uopt_q   <= WORD_RESET;
      ucompl_q <= WORD_RESET;
    end else begin
      if (cap_u0) begin
        uopt_q <= usb_present ? mif.rdata : WORD_RESET;
      end
      if (cap_u1) begin
        ucompl_q <= usb_present ? mif.rdata : WORD_RESET;
      end
    end
  end

  // completion wins over a start in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      valid_q <= 1'b0;
    end else if (cap_u1) begin
      valid_q <= 1'b1;
    end else if (start_scan) begin
      valid_q <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // field checks and outputs
  // -------------------------------------------------------------
  wire rsvd_ok  = (uopt_q[15:OPT_RSVD_LO] == '0);
  wire ver_ok   = (uopt_q[1:0] == USB_VER_1X) || (uopt_q[1:0] == USB_VER_20);
  wire compl_ok = (ucompl_q == {COMPL_UPPER, COMPL_LOWER});
  wire modem_ok = !modem_present || (mvend_q != WORD_RESET);
  wire usb_ok   = !usb_present || (rsvd_ok && ver_ok && compl_ok);

  assign modem_vendor_bits   = mvend_q;
  assign modem_model_bits    = mmodel_q;
  assign hub_flag            = uopt_q[OPT_HUB_BIT];
  assign wake_capable_flag   = uopt_q[OPT_WAKE_BIT];
  assign usb_version_field   = uopt_q[1:0];
  assign usb_compliance_bits = ucompl_q;
  assign map_valid           = valid_q;

  // one bit per check, so software can tell which field made a section unusable
  logic [31:0] status_word;
  always_comb begin
    status_word                = 32'h0000_0000;
    status_word[ST_MODEM_OK]   = modem_ok;
    status_word[ST_USB_OK]     = usb_ok;
    status_word[ST_RSVD_OK]    = rsvd_ok;
    status_word[ST_VER_OK]     = ver_ok;
    status_word[ST_COMPL_OK]   = compl_ok;
    status_word[ST_MODEM_PRES] = modem_present;
    status_word[ST_USB_PRES]   = usb_present;
    status_word[ST_BUSY]       = scan_busy;
  end

  // -------------------------------------------------------------
  // axi read channel
  // -------------------------------------------------------------
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [31:0] rd_word;
  logic        rd_known;

  always_comb begin
    rd_known = 1'b1;
    unique case (s_axi_araddr)
      REG_MODEM_VENDOR: rd_word = {16'h0, mvend_q};
      REG_MODEM_MODEL:  rd_word = {16'h0, mmodel_q};
      REG_USB_OPTION:   rd_word = {16'h0, uopt_q};
      REG_USB_COMPL:    rd_word = {16'h0, ucompl_q};
      REG_MODEM_PTR:    rd_word = {16'h0, modem_ptr_q};
      REG_USB_PTR:      rd_word = {16'h0, usb_ptr_q};
      REG_STATUS:       rd_word = status_word;
      REG_MEM_ADDR:     rd_word = {24'h0, mem_addr_q};
      default: begin
        rd_word  = 32'h0000_0000;
        rd_known = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- verif/rmu_host_model.sv ----
// rmu_host_model: host firmware side, an axi4-lite master with word tasks
// assumes the slave on the same clock; one transfer at a time
`default_nettype none
module rmu_host_model
  import rmu_pkg::*;
#(
  parameter logic BOARD_V2   = 1'b1,
  parameter logic BOARD_WAKE = 1'b1,
  parameter logic BOARD_HUB  = 1'b1
) (
  // clock
  input wire logic        aclk,
  // write channels
  output logic [7:0]      s_axi_awaddr,
  output logic            s_axi_awvalid,
  input wire logic        s_axi_awready,
  output logic [31:0]     s_axi_wdata,
  output logic [3:0]      s_axi_wstrb,
  output logic            s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  output logic            s_axi_bready,
  // read channels
  output logic [7:0]      s_axi_araddr,
  output logic            s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  output logic            s_axi_rready
);
  // ---------------------------------------------------------------
  // bus tasks and host judgement
  // ---------------------------------------------------------------
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    // no limit here: only the bench watchdog ends a stalled transfer
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {v, resp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  // reserved speed codes count as unusable, never as a guess
  function automatic logic usb_fits(input logic [15:0] o);
    logic ver_ok;
    ver_ok = (o[1:0] == USB_VER_1X) || (o[1:0] == USB_VER_20 && BOARD_V2);
    return ver_ok && (!o[OPT_WAKE_BIT] || BOARD_WAKE) && (!o[OPT_HUB_BIT] || BOARD_HUB);
  endfunction
  function automatic logic [15:0] sec_words(input logic [15:0] p, input logic [15:0] nxt);
    return nxt - p;
  endfunction
endmodule
`default_nettype wire

// ---- verif/rmu_props.sv ----
// rmu_props: bus timing and field checks on the rmu_top ports
// assumes one clock with a synchronous active-low reset
`default_nettype none
module rmu_props
  import rmu_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  // decoded fields
  input wire logic [15:0] modem_vendor_bits,
  input wire logic [15:0] modem_model_bits,
  input wire logic        hub_flag,
  input wire logic        wake_capable_flag,
  input wire logic [1:0]  usb_version_field,
  input wire logic [15:0] usb_compliance_bits,
  input wire logic        map_valid
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic rd_hs = s_axi_arvalid && s_axi_arready;
  wire logic wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire logic start = wr_hs && (s_axi_awaddr == REG_STATUS) && s_axi_wdata[0];
  AST_WRITE_ANSWER: assert property (wr_hs |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_READ_ANSWER: assert property (rd_hs |=> s_axi_rvalid)
    else $error("read data late");
  AST_READ_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  // reset itself is the cause here, so this one is never disabled
  AST_RESET_CLEAR: assert property (disable iff (1'b0)
    !aresetn |=> !map_valid && !s_axi_bvalid && !s_axi_rvalid && modem_vendor_bits == 16'h0000)
    else $error("outputs not cleared by reset");
  AST_VENDOR_READ: assert property (
    rd_hs && s_axi_araddr == REG_MODEM_VENDOR |=> s_axi_rdata == {16'h0000, $past(modem_vendor_bits)})
    else $error("vendor register differs from field");
  AST_MODEL_READ: assert property (
    rd_hs && s_axi_araddr == REG_MODEM_MODEL |=> s_axi_rdata == {16'h0000, $past(modem_model_bits)})
    else $error("model register differs from field");
  AST_OPTION_READ: assert property (
    rd_hs && s_axi_araddr == REG_USB_OPTION |=>
    s_axi_rdata[3:0] == {$past(hub_flag), $past(wake_capable_flag), $past(usb_version_field)})
    else $error("option register differs from flags");
  AST_COMPL_READ: assert property (
    rd_hs && s_axi_araddr == REG_USB_COMPL |=> s_axi_rdata == {16'h0000, $past(usb_compliance_bits)})
    else $error("compliance register differs from field");
  AST_SCAN_CYCLE: assert property (start |=> ##[0:3] !map_valid ##[1:40] map_valid)
    else $error("scan did not clear and set map_valid");
  CVR_SCAN: cover property (start);
  CVR_OPTION: cover property (rd_hs && s_axi_araddr == REG_USB_OPTION);
  CVR_VALID: cover property ($rose(map_valid));
endmodule
bind rmu_top rmu_props chk_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .modem_vendor_bits, .modem_model_bits, .hub_flag, .wake_capable_flag, .usb_version_field,
  .usb_compliance_bits, .map_valid);
`default_nettype wire

// ---- verif/rmu_top_bench.sv ----
// rmu_top_bench: register-level tests of rmu_top through the host model
// assumes a free-running 200 MHz clock; reset held for ten cycles
`default_nettype none
module rmu_top_bench import rmu_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  int          errors = 0;
  int          samples_checked = 0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, usb_version_field;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] modem_vendor_bits, modem_model_bits, usb_compliance_bits, opt;
  logic        hub_flag, wake_capable_flag, map_valid;
  // ---------------------------------------------------------------
  // clock, parts and tasks
  // ---------------------------------------------------------------
  always #2.5 aclk = ~aclk;
  rmu_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .modem_vendor_bits,
    .modem_model_bits, .hub_flag, .wake_capable_flag, .usb_version_field, .usb_compliance_bits, .map_valid);
  rmu_host_model host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [7:0] w, input logic [15:0] v);
    host.wr(REG_MEM_ADDR, {24'h000000, w}, r);
    host.wr(REG_MEM_DATA, {16'h0000, v}, r);
  endtask
  // leaves the last status word in d for the caller
  task automatic scan();
    host.wr(REG_STATUS, 32'h0000_0001, r);
    for (int n = 0; n < 40; n++) begin
      host.rd(REG_STATUS, d, r);
      if (d[31] === 1'b0) break;
    end
    chk({31'h0, map_valid}, 32'h1);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    #50us;
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      host.rd(8'(i * 4), d, r);
      if (i != 2) chk(d, 32'h0);
    end
    host.rd(8'h40, d, r);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR});
    host.wr(8'h44, 32'h5, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    put(MODEM_PTR_WORD, 16'h0020);
    put(USB_PTR_WORD, 16'h0028);
    put(8'h20, 16'habcd);
    put(8'h20 + WORD2_OFFSET, 16'h1234);
    put(8'h28 + WORD2_OFFSET, {COMPL_UPPER, COMPL_LOWER});
    for (int v = 0; v < 4; v++) begin
      opt = {12'h000, v[0], v[1], v[1:0]};
      put(8'h28, opt);
      scan();
      chk({30'h0, d[ST_VER_OK], d[ST_USB_OK]}, {30'h0, v < 2, v < 2});
      chk({30'h0, d[ST_USB_PRES], d[ST_MODEM_PRES]}, 32'h3);
      chk({modem_vendor_bits, modem_model_bits}, 32'habcd_1234);
      chk({16'h0, usb_compliance_bits}, 32'h0100);
      chk({28'h0, hub_flag, wake_capable_flag, usb_version_field}, {28'h0, opt[3:0]});
      host.rd(REG_USB_OPTION, d, r);
      chk(d, {16'h0, opt});
      chk({31'h0, host.usb_fits(opt)}, {31'h0, v < 2});
    end
    put(8'h28, 16'h0011);
    put(8'h2a, 16'h0200);
    put(MODEM_PTR_WORD, 16'h0000);
    scan();
    chk({27'h0, d[ST_COMPL_OK], d[ST_VER_OK], d[ST_RSVD_OK], d[ST_USB_OK], d[ST_MODEM_PRES]}, 32'h08);
    chk({16'h0, modem_vendor_bits}, 32'h0);
    put(USB_PTR_WORD, 16'h0000);
    scan();
    chk({15'h0, d[ST_USB_PRES], usb_compliance_bits}, 32'h0);
    chk({16'h0, host.sec_words(16'h0020, 16'h0028)}, 32'h0000_0008);
    tally_and_finish();
  end
endmodule
`default_nettype wire
